// ==== include/sfm_pkg.sv ====
package sfm_pkg;
  localparam int          ADDR_W       = 13;
  localparam int          DATA_W       = 8;
  localparam int          MEM_DEPTH    = 8192;
  localparam logic [12:0] ADDR_LAST    = 13'h1FFF;
  localparam logic [12:0] ADDR_FIRST   = 13'h0000;
  localparam logic [12:0] GUARD_QTR    = 13'h1800;
  localparam logic [12:0] GUARD_HALF   = 13'h1000;
  localparam logic [7:0]  OP_SET_WL    = 8'h06;
  localparam logic [7:0]  OP_CLR_WL    = 8'h04;
  localparam logic [7:0]  OP_STAT_RD   = 8'h05;
  localparam logic [7:0]  OP_STAT_WR   = 8'h01;
  localparam logic [7:0]  OP_MEM_RD    = 8'h03;
  localparam logic [7:0]  OP_MEM_WR    = 8'h02;
  localparam int          STAT_WPEN    = 7;
  localparam int          STAT_BG1     = 3;
  localparam int          STAT_BG0     = 2;
  localparam int          STAT_WL      = 1;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [2:0]  BIT_FIRST    = 3'h0;
  localparam logic [3:0]  LINK_DIV     = 4'h5;
  typedef enum logic [1:0] {SFM_IDLE, SFM_LOAD, SFM_CHK} sfm_mstate_t;
endpackage

// ==== include/sfm_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sfm_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so_o;
  logic so_oe;
  logic hold_n;
  logic wp_n;
  modport dev  (input sck, cs_n, si, hold_n, wp_n, output so_o, so_oe);
  modport host (output sck, cs_n, si, hold_n, wp_n, input so_o, so_oe);
endinterface
`default_nettype wire

// ==== design/sfm_device.sv ====
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - master sends set-write-latch before memory writes
// - two address bytes, low 13 bits used
// - address increments per byte, wraps to zero
// - data shifts most significant bit first
// - select rising ends any write transfer
// - protected block stops increment, drops data
// - byte committed at its eighth bit
// - partial bytes are never committed
// - read data follows address, successive addresses
// - input line ignored during read data
// - select rising ends read, output released
// - hold low with clock low pauses
// - hold high with clock low resumes
// - master changes hold only while clock low
// - six eight-bit opcodes as listed
// - latch cleared at select rise after writes
// - guard bits pick protected address range
// - clock level at select fall stored in mode3, which nothing reads
module sfm_device
  import sfm_pkg::*;
(
  input  wire logic clock,      // system clock
  input  wire logic sys_rst,    // async reset, high
  input  wire logic clk_en,     // freezes all state when low
  sfm_if.dev        link,       // serial pins
  output logic      write_latch_flag, // write latch state
  output logic      wr_pulse,   // one-cycle array commit
  output logic [12:0] wr_addr,  // committed address
  output logic [7:0]  wr_data   // committed byte
);
  import sfm_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] sck_s, cs_s, si_s, hold_s, wp_s;
  logic       sck_q, cs_q, hold_q;
  logic       next_sck_q, next_cs_q, next_hold_q;
  logic [14:0] next_sync;

  always_comb begin
    next_sync   = {sck_s[1:0], link.sck, cs_s[1:0], link.cs_n, si_s[1:0], link.si,
                   hold_s[1:0], link.hold_n, wp_s[1:0], link.wp_n};
    next_sck_q  = (sck_s[2] == sck_s[1]) ? sck_s[2] : sck_q;
    next_cs_q   = (cs_s[2] == cs_s[1]) ? cs_s[2] : cs_q;
    next_hold_q = (hold_s[2] == hold_s[1] && !sck_q) ? hold_s[2] : hold_q;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      // synchronisers start at the idle pin levels so reset brings no false select
      sck_s  <= '0;
      cs_s   <= '1;
      si_s   <= '0;
      hold_s <= '1;
      wp_s   <= '1;
      sck_q  <= 1'b0;
      cs_q   <= 1'b1;
      hold_q <= 1'b1;
    end else if (clk_en) begin
      {sck_s, cs_s, si_s, hold_s, wp_s} <= next_sync;
      sck_q  <= next_sck_q;
      cs_q   <= next_cs_q;
      hold_q <= next_hold_q;
    end
  end

  wire logic si_v   = si_s[2];
  wire logic cs_fall = cs_q & ~next_cs_q;
  wire logic cs_rise = ~cs_q & next_cs_q;
  wire logic act    = ~cs_q & hold_q;
  wire logic rise   = act & ~sck_q & next_sck_q;
  wire logic fall   = act & sck_q & ~next_sck_q;

  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  function automatic logic guarded(input logic [1:0] bg, input logic [12:0] a);
    case (bg)
      2'b01:   guarded = (a >= GUARD_QTR);
      2'b10:   guarded = (a >= GUARD_HALF);
      2'b11:   guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  endfunction

  logic [7:0]  mem [MEM_DEPTH];
  logic [7:0]  sh, next_sh, obuf, next_obuf, op, next_op, stat, next_stat;
  logic [2:0]  bitc, next_bitc;
  logic [1:0]  phase, next_phase;   // 0 op, 1 addr hi, 2 addr lo, 3 data
  logic [12:0] addr, next_addr;
  logic        wl, next_wl, stopped, next_stopped, mode3, next_mode3;
  logic        so_q, next_so_q, did_wr, next_did_wr;
  logic        n_wr;
  logic [7:0]  byte_in;

  always_comb begin
    next_sh = sh; next_obuf = obuf; next_op = op; next_stat = stat;
    next_bitc = bitc; next_phase = phase; next_addr = addr; next_wl = wl;
    next_stopped = stopped; next_mode3 = mode3; next_so_q = so_q;
    next_did_wr = did_wr; n_wr = 1'b0;
    byte_in = {sh[6:0], si_v};
    if (cs_fall) begin
      next_mode3 = sck_q;
      next_bitc = BIT_FIRST; next_phase = 2'd0;
      next_stopped = 1'b0; next_did_wr = 1'b0;
    end
    if (cs_rise) begin
      if (did_wr) next_wl = 1'b0;
      next_phase = 2'd0; next_bitc = BIT_FIRST;
    end else if (rise) begin
      if (!(phase == 2'd3 && op == OP_MEM_RD)) begin
        next_sh = byte_in;
      end
      next_bitc = bitc + 3'd1;
      if (bitc == BIT_LAST) begin
        case (phase)
          2'd0: begin
            next_op = byte_in;
            if (byte_in == OP_SET_WL) next_wl = 1'b1;
            if (byte_in == OP_CLR_WL || ((byte_in == OP_STAT_WR || byte_in == OP_MEM_WR)
                && wl)) next_did_wr = 1'b1;
            if (byte_in == OP_MEM_RD || byte_in == OP_MEM_WR) next_phase = 2'd1;
            else if (byte_in == OP_STAT_RD || byte_in == OP_STAT_WR) begin
              next_phase = 2'd3;
              next_obuf = {stat[7:2], wl, 1'b0};
            end else next_phase = 2'd3;
          end
          2'd1: begin
            next_addr = {byte_in[4:0], addr[7:0]};
            next_phase = 2'd2;
          end
          2'd2: begin
            next_addr = {addr[12:8], byte_in};
            next_phase = 2'd3;
            next_obuf = mem[{addr[12:8], byte_in}];
          end
          default: begin
            if (op == OP_MEM_WR) begin
              if (wl && !stopped && !guarded(stat[3:2], addr)) begin
                n_wr = 1'b1;
                next_addr = (addr == ADDR_LAST) ? ADDR_FIRST : addr + 13'd1;
              end else next_stopped = 1'b1;
            end else if (op == OP_MEM_RD) begin
              next_addr = (addr == ADDR_LAST) ? ADDR_FIRST : addr + 13'd1;
              next_obuf = mem[(addr == ADDR_LAST) ? ADDR_FIRST : addr + 13'd1];
            end else if (op == OP_STAT_WR && wl && !(stat[STAT_WPEN] && !wp_s[2])) begin
              next_stat = {byte_in[7], 3'b000, byte_in[3:2], 2'b00};
            end
          end
        endcase
      end
    end else if (fall && phase == 2'd3 && (op == OP_MEM_RD || op == OP_STAT_RD)) begin
      next_so_q = obuf[BIT_LAST - bitc];
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sh       <= '0;
      obuf     <= '0;
      op       <= '0;
      stat     <= '0;
      bitc     <= '0;
      phase    <= '0;
      addr     <= '0;
      wl       <= 1'b0;
      stopped  <= 1'b0;
      mode3    <= 1'b0;
      so_q     <= 1'b0;
      did_wr   <= 1'b0;
      wr_pulse <= 1'b0;
      wr_addr  <= '0;
      wr_data  <= '0;
    end else if (clk_en) begin
      sh       <= next_sh;
      obuf     <= next_obuf;
      op       <= next_op;
      stat     <= next_stat;
      bitc     <= next_bitc;
      phase    <= next_phase;
      addr     <= next_addr;
      wl       <= next_wl;
      stopped  <= next_stopped;
      mode3    <= next_mode3;
      so_q     <= next_so_q;
      did_wr   <= next_did_wr;
      wr_pulse <= n_wr;
      if (n_wr) begin
        wr_addr <= addr;
        wr_data <= byte_in;
      end
    end
  end

  // array has no reset: contents are nonvolatile in intent
  always_ff @(posedge clock) begin
    if (clk_en && n_wr) mem[addr] <= byte_in;
  end

  // each bit is set up at a fall and taken by the host at the next fall, so the pin
  // never moves while the link clock is high, byte boundaries included
  wire logic reading   = phase == 2'd3 && (op == OP_MEM_RD || op == OP_STAT_RD);
  assign link.so_o  = so_q;
  assign link.so_oe = reading & act;
  assign write_latch_flag = wl;
endmodule
`default_nettype wire

// ==== design/sfm_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfm_host
  import sfm_pkg::*;
(
  input  wire logic        clock,     // system clock
  input  wire logic        sys_rst,   // async reset, high
  input  wire logic        clk_en,    // freezes all state when low
  sfm_if.host              link,      // serial pins
  input  wire logic        start,     // begin a transfer
  input  wire logic [3:0]  tx_len,    // bytes to send incl. opcode
  input  wire logic [7:0]  tx_byte [8], // bytes to send
  input  wire logic [3:0]  rx_len,    // bytes to read afterwards
  input  wire logic        pause,     // request hold
  output logic             busy,      // transfer in progress
  output logic             rx_valid,  // one-cycle pulse per read byte
  output logic [7:0]       rx_byte    // read byte
);
  import sfm_pkg::*;

  // ----------------------------------------
  // clock divider and shifter
  // ----------------------------------------
  logic [3:0] div, next_div;
  logic       sck, next_sck, cs_n, next_cs_n, hold_n, next_hold_n;
  logic [3:0] idx, next_idx, rxn, next_rxn;
  logic [2:0] bitc, next_bitc;
  logic [7:0] sh, next_sh, next_rx;
  logic       next_rxv;
  logic [2:0] so_s;
  sfm_mstate_t st, next_st;

  always_comb begin
    next_div = div; next_sck = sck; next_cs_n = cs_n; next_hold_n = hold_n;
    next_idx = idx; next_rxn = rxn; next_bitc = bitc; next_sh = sh;
    next_rx = rx_byte; next_rxv = 1'b0; next_st = st;
    case (st)
      SFM_IDLE: if (start) begin
        next_cs_n = 1'b0; next_idx = 4'd0; next_rxn = rx_len;
        next_bitc = BIT_FIRST; next_st = SFM_LOAD; next_div = '0;
      end
      SFM_LOAD: begin
        if (!sck && pause) next_hold_n = 1'b0;
        else if (!sck) next_hold_n = 1'b1;
        if (hold_n && !(pause && !sck)) begin
          next_div = div + 4'd1;
          if (div == LINK_DIV) begin
            next_div = '0;
            next_sck = ~sck;
            if (sck) begin
              // read bits taken at the fall: the reply lags through three synchroniser stages
              next_sh   = {sh[6:0], so_s[2]};
              next_bitc = bitc + 3'd1;
              if (bitc == BIT_LAST) begin
                next_idx = idx + 4'd1;
                if (idx >= tx_len) begin
                  next_rx  = next_sh;
                  next_rxv = 1'b1;
                  next_rxn = rxn - 4'd1;
                end
                if ((idx >= tx_len) ? (rxn == 4'd1) : (idx + 4'd1 >= tx_len && rxn == 4'd0))
                  next_st = SFM_CHK;
              end
            end
          end
        end
      end
      SFM_CHK: begin
        next_cs_n = 1'b1; next_st = SFM_IDLE;
      end
      default: next_st = SFM_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div <= '0; sck <= 1'b0; cs_n <= 1'b1; hold_n <= 1'b1; idx <= '0; rxn <= '0;
      bitc <= '0; sh <= '0; rx_byte <= '0; rx_valid <= 1'b0; so_s <= '0; st <= SFM_IDLE;
    end else if (clk_en) begin
      div <= next_div; sck <= next_sck; cs_n <= next_cs_n; hold_n <= next_hold_n;
      idx <= next_idx; rxn <= next_rxn; bitc <= next_bitc; sh <= next_sh;
      rx_byte <= next_rx; rx_valid <= next_rxv; so_s <= {so_s[1:0], link.so_o}; st <= next_st;
    end
  end

  wire logic [7:0] cur = (idx < 4'd8) ? tx_byte[idx[2:0]] : 8'h00;
  assign link.sck    = sck;
  assign link.cs_n   = cs_n;
  assign link.hold_n = hold_n;
  assign link.wp_n   = 1'b1;
  assign link.si     = (idx < tx_len) ? cur[BIT_LAST - bitc] : 1'b0;
  assign busy        = st != SFM_IDLE;
endmodule
`default_nettype wire

// ==== bench/sfm_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfm_monitor (
  input wire logic clock,   // system clock
  input wire logic sys_rst, // async reset
  input wire logic sck,     // link clock
  input wire logic cs_n,    // select
  input wire logic si,      // serial in
  input wire logic so_o,    // serial out
  input wire logic so_oe,   // out enable
  input wire logic hold_n,  // hold request
  input wire logic wp_n     // guard pin
);
  // ----
  // link checks
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence idle8; cs_n [*8]; endsequence
  sequence held8; !hold_n [*8]; endsequence
  a_release_when_idle: assert property (idle8 |-> !so_oe)
    else $error("serial out driven while deselected");
  a_release_in_hold: assert property (held8 |-> !so_oe)
    else $error("serial out driven during hold");
  a_hold_sck_low: assert property ($changed(hold_n) |-> !sck)
    else $error("hold changed with clock high");
  a_sck_framed: assert property (sck |-> !cs_n)
    else $error("link clock high outside a frame");
  a_so_steady_high: assert property (so_oe && $past(so_oe) && sck && $past(sck)
    |-> $stable(so_o))
    else $error("serial out moved while clock high");
  a_drive_needs_sel: assert property ($rose(so_oe) |-> !cs_n && hold_n)
    else $error("serial out enabled without select");
  a_sck_half_period: assert property ($rose(sck) |-> sck [*5])
    else $error("link clock high phase too short");
  a_read_ends_cs: assert property ($rose(cs_n) |-> ##[1:8] !so_oe)
    else $error("serial out not released after select rise");
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sfm_pkg::*;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        start = 1'b0;
  logic        pause = 1'b0;
  logic [3:0]  tx_len = 4'h0;
  logic [3:0]  rx_len = 4'h0;
  logic [7:0]  tx_byte [8];
  logic        busy, rx_valid, write_latch_flag, wr_pulse;
  logic [7:0]  rx_byte, wr_data;
  logic [12:0] wr_addr;
  logic [7:0]  shadow [int];
  logic [20:0] wr_q [$];
  logic [7:0]  rx_q [$];
  logic [1:0]  g = 2'h0;
  logic        wl = 1'b0;
  logic [15:0] ra;
  int          seed = 17;
  int          err_count = 0;
  int          comparisons = 0;
  sfm_if link_a ();
  always #4 clock = ~clock;
  sfm_device sfm_device_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1),
    .link(link_a.dev), .write_latch_flag(write_latch_flag), .wr_pulse(wr_pulse),
    .wr_addr(wr_addr), .wr_data(wr_data));
  sfm_host sfm_host_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1),
    .link(link_a.host), .start(start), .tx_len(tx_len), .tx_byte(tx_byte),
    .rx_len(rx_len), .pause(pause), .busy(busy), .rx_valid(rx_valid), .rx_byte(rx_byte));
  sfm_monitor sfm_monitor_inst (.clock(clock), .sys_rst(sys_rst), .sck(link_a.sck),
    .cs_n(link_a.cs_n), .si(link_a.si), .so_o(link_a.so_o), .so_oe(link_a.so_oe),
    .hold_n(link_a.hold_n), .wp_n(link_a.wp_n));
  always @(posedge clock) begin
    if (wr_pulse === 1'b1) wr_q.push_back({wr_addr, wr_data});
    if (rx_valid === 1'b1) rx_q.push_back(rx_byte);
  end
  // ----
  // helpers
  // ----
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic logic prot(input logic [12:0] p);
    case (g)
      2'h0: return 1'b0;
      2'h1: return p >= GUARD_QTR;
      2'h2: return p >= GUARD_HALF;
      default: return 1'b1;
    endcase
  endfunction
  task automatic xfer(input int n, input int r);
    int k;
    wr_q.delete();
    rx_q.delete();
    @(posedge clock);
    #1;
    tx_len = 4'(n);
    rx_len = 4'(r);
    start = 1'b1;
    @(posedge clock);
    #1;
    start = 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 4000) begin
      @(posedge clock);
      k++;
    end
    chk("idle", 24'h0, {23'h0, busy});
    repeat (12) @(posedge clock);
    #1;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] v, input int n);
    tx_byte[0] = op;
    tx_byte[1] = v;
    xfer(n, 0);
    if (op == OP_SET_WL) wl = 1'b1;
    if (op == OP_STAT_WR || op == OP_CLR_WL) wl = 1'b0;
    chk("latch", {23'h0, wl}, {23'h0, write_latch_flag});
  endtask
  task automatic wburst(input logic [15:0] a, input int n);
    int c;
    logic [12:0] p;
    tx_byte[0] = OP_MEM_WR;
    tx_byte[1] = a[15:8];
    tx_byte[2] = a[7:0];
    for (int i = 0; i < n; i++) tx_byte[3+i] = 8'($random(seed));
    c = 0;
    p = a[12:0];
    while (wl && c < n && !prot(p)) begin
      shadow[int'(p)] = tx_byte[3+c];
      p++;
      c++;
    end
    xfer(3 + n, 0);
    wl = 1'b0;
    chk("commits", 24'(c), 24'(wr_q.size()));
    for (int i = 0; i < c && i < wr_q.size(); i++)
      chk("commit", {3'h0, 13'(a[12:0] + 13'(i)), tx_byte[3+i]}, {3'h0, wr_q[i]});
  endtask
  task automatic rburst(input logic [15:0] a, input int n);
    tx_byte[0] = OP_MEM_RD;
    tx_byte[1] = a[15:8];
    tx_byte[2] = a[7:0];
    xfer(3, n);
    chk("rx count", 24'(n), 24'(rx_q.size()));
    for (int i = 0; i < n && i < rx_q.size(); i++)
      chk("rx", {16'h0, shadow[int'(13'(a[12:0] + 13'(i)))]}, {16'h0, rx_q[i]});
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    foreach (tx_byte[i]) tx_byte[i] = 8'h00;
    repeat (4) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    chk("latch rst", 24'h0, {23'h0, write_latch_flag});
    wburst(16'h0100, 2);
    for (int k = 0; k < 4; k++) begin
      cmd(OP_SET_WL, 8'h00, 1);
      cmd(OP_STAT_WR, 8'(k << 2), 2);
      g = 2'(k);
      tx_byte[0] = OP_STAT_RD;
      xfer(1, 1);
      chk("status", {16'h0, 4'h0, g, 2'h0}, {16'h0, rx_q[0]});
      cmd(OP_SET_WL, 8'h00, 1);
      wburst(16'h17FE, 4);
    end
    cmd(OP_SET_WL, 8'h00, 1);
    cmd(OP_STAT_WR, 8'h00, 2);
    g = 2'h0;
    cmd(OP_SET_WL, 8'h00, 1);
    cmd(OP_CLR_WL, 8'h00, 1);
    cmd(OP_SET_WL, 8'h00, 1);
    wburst(16'hFFFE, 5);
    repeat (3) begin
      cmd(OP_SET_WL, 8'h00, 1);
      ra = 16'($random(seed));
      wburst(ra, 5);
    end
    rburst(16'h3FFE, 5);
    fork
      begin
        repeat (350) @(posedge clock);
        #1 pause = 1'b1;
        repeat (200) @(posedge clock);
        #1 pause = 1'b0;
      end
    join_none
    rburst(ra, 5);
    end_of_test();
  end
  initial begin
    #600000;
    err_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
